//--- core/ffm_axis.sv
`timescale 1ns/100ps
`default_nettype none
// magnitude compare of one axis against the selected threshold
module ffm_axis (
   ffm_axis_if.axis ax
);
   // sign and magnitude of the sample
   wire logic is_neg = ax.sample[ffm_pkg::ACC_W-1];
   wire logic [ffm_pkg::ACC_W-1:0] mag = is_neg ? -ax.sample : ax.sample;
   // shared threshold scaled to sample counts
   wire logic [ffm_pkg::ACC_W-1:0] ths_c =
      ffm_pkg::ffm_acc_t'(ax.ths_common) << ffm_pkg::COMMON_SHIFT;
   // own threshold widened to sample width
   wire logic [ffm_pkg::ACC_W-1:0] ths_i = ffm_pkg::ffm_acc_t'(ax.ths_indiv);
   // threshold selection
   wire logic [ffm_pkg::ACC_W-1:0] ths_eff = ax.use_indiv ? ths_i : ths_c;
   // compare results
   assign ax.high = mag > ths_eff;
   assign ax.low = mag <= ths_eff;
   assign ax.neg = is_neg;
endmodule
`default_nettype wire

//--- core/ffm_axis_if.sv
`timescale 1ns/100ps
`default_nettype none
// one axis comparator link: sample and thresholds in, flags out
interface ffm_axis_if;
   logic [ffm_pkg::ACC_W-1:0] sample; // signed sample
   logic [ffm_pkg::ATH_W-1:0] ths_indiv; // own 13-bit threshold
   logic [ffm_pkg::CTH_W-1:0] ths_common; // shared 7-bit threshold
   logic use_indiv; // pick own threshold
   logic high; // magnitude above threshold
   logic low; // magnitude at or below threshold
   logic neg; // sample negative
   modport ctrl (output sample, ths_indiv, ths_common, use_indiv,
                 input high, low, neg);
   modport axis (input sample, ths_indiv, ths_common, use_indiv,
                 output high, low, neg);
endinterface
`default_nettype wire

//--- core/ffm_detector.sv
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ffm_detector (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [ffm_pkg::ACC_W-1:0] accel_x,
   input wire logic [ffm_pkg::ACC_W-1:0] accel_y,
   input wire logic [ffm_pkg::ACC_W-1:0] accel_z,
   input wire logic sample_valid,
   output logic irq,
   output logic int1_freefall_motion,
   output logic int2_freefall_motion
);
   localparam int AW = ffm_pkg::ACC_W;

   ////////////////////////////////////////////////////////////////////////
   // register storage
   logic [7:0] freefall_motion_config; // enables, mode, latch
   logic [7:0] freefall_motion_common_threshold; // dbmode and 7-bit ths
   logic [7:0] debounce_count; // samples needed to set the flag
   logic [7:0] axis_ths [6]; // x hi, x lo, y hi, y lo, z hi, z lo
   logic [5:0] freefall_motion_source; // per-axis event and polarity
   logic event_active_flag; // combined, debounced event
   logic [7:0] dbcnt; // debounce counter
   logic deb_state; // debounced detection
   logic [1:0] int_status; // sticky events
   logic [1:0] int_mask; // interrupt mask
   logic [1:0] int_ctrl; // pin enable and routing

   ////////////////////////////////////////////////////////////////////////
   // bus decode
   wire logic [7:0] idx = avs_address[9:2]; // word index
   wire logic req = avs_read | avs_write; // request pending
   wire logic acc = req & ~avs_waitrequest; // accepted this edge
   wire logic wr_acc = acc & avs_write & avs_byteenable[0];
   wire logic src_read = acc & avs_read & (idx == ffm_pkg::IDX_SRC);
   // per-axis threshold window
   wire logic hit_ath = (idx >= ffm_pkg::IDX_THS_XM) &&
                        (idx <= ffm_pkg::IDX_THS_ZL);
   wire logic [7:0] ath_off = idx - ffm_pkg::IDX_THS_XM;
   wire logic [2:0] ath_idx = ath_off[2:0];

   ////////////////////////////////////////////////////////////////////////
   // configuration fields
   wire logic latch = freefall_motion_config[ffm_pkg::CFG_LATCH];
   wire logic or_mode = freefall_motion_config[ffm_pkg::CFG_OR];
   // axis enables x, y, z
   wire logic [2:0] axis_en =
      freefall_motion_config[ffm_pkg::CFG_XEN +: 3];
   // debounce mode, independent of threshold selection
   wire logic dbmode =
      freefall_motion_common_threshold[ffm_pkg::THS_DBMODE];
   wire logic use_indiv = axis_ths[0][ffm_pkg::THS_XYZ_EN];

   ////////////////////////////////////////////////////////////////////////
   // per-axis comparators
   ffm_axis_if ax_if[3] ();
   wire logic [3*AW-1:0] accel_all = {accel_z, accel_y, accel_x};
   wire logic [2:0] ax_high; // above threshold
   wire logic [2:0] ax_low; // at or below threshold
   wire logic [2:0] ax_neg; // negative sample
   wire logic [2:0] ax_evt; // enabled axis event
   wire logic [5:0] new_flags; // fresh source flags
   generate
      for (genvar g = 0; g < 3; g++) begin : g_axis
         assign ax_if[g].sample = accel_all[g*AW +: AW];
         // own threshold from high and low bytes
         assign ax_if[g].ths_indiv =
            {axis_ths[2*g][ffm_pkg::ATH_HI_W-1:0], axis_ths[2*g+1]};
         assign ax_if[g].ths_common =
            freefall_motion_common_threshold[ffm_pkg::CTH_W-1:0];
         assign ax_if[g].use_indiv = use_indiv;
         assign ax_high[g] = ax_if[g].high;
         assign ax_low[g] = ax_if[g].low;
         assign ax_neg[g] = ax_if[g].neg;
         // event then polarity, 0 positive 1 negative
         assign new_flags[2*g+1] = ax_evt[g];
         assign new_flags[2*g] = ax_evt[g] & ax_neg[g];
         ffm_axis u_axis (
            .ax(ax_if[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // combination of axes
   // motion: any enabled axis high
   wire logic cond_or = |(ax_high & axis_en);
   // freefall: every enabled axis low, at least one enabled
   wire logic cond_and = (|axis_en) & (&(ax_low | ~axis_en));
   wire logic cond = or_mode ? cond_or : cond_and;
   // disabled axes raise no event
   assign ax_evt = (or_mode ? ax_high : ax_low) & axis_en;

   ////////////////////////////////////////////////////////////////////////
   // debounce filter
   wire logic cnt_full = dbcnt >= debounce_count;
   wire logic [7:0] cnt_up = cnt_full ? debounce_count : dbcnt + 8'h01;
   wire logic [7:0] cnt_dn = (dbcnt == 8'h00) ? 8'h00 : dbcnt - 8'h01;
   // mode 1 clears, mode 0 counts down when condition drops
   wire logic [7:0] next_dbcnt = cond ? cnt_up :
                                 (dbmode ? 8'h00 : cnt_dn);
   wire logic next_deb = cond ?
      (deb_state | (next_dbcnt >= debounce_count)) :
      (~dbmode & deb_state & (next_dbcnt != 8'h00));

   ////////////////////////////////////////////////////////////////////////
   // event flag and source flags
   // latched: set wins over read clear unlatched follows
   wire logic held_ea = latch ? (event_active_flag & ~src_read)
                              : event_active_flag;
   wire logic next_ea = sample_valid ?
      (latch ? (held_ea | next_deb) : next_deb) : held_ea;
   // freeze while latched and set
   wire logic frozen = latch & event_active_flag & ~src_read;
   wire logic [5:0] kept_flags = (latch & src_read) ? 6'h00
                                                    : freefall_motion_source;
   wire logic [5:0] next_src = (sample_valid & ~frozen) ? new_flags
                                                         : kept_flags;
   // disabled axes read zero
   wire logic [5:0] src_mask = {{2{axis_en[2]}}, {2{axis_en[1]}},
                                {2{axis_en[0]}}};
   // source layout
   wire logic [7:0] src_view = {event_active_flag, 1'b0,
                                freefall_motion_source & src_mask};

   ////////////////////////////////////////////////////////////////////////
   // interrupt status
   wire logic [1:0] int_evt = {event_active_flag & ~next_ea,
                               ~event_active_flag & next_ea};
   wire logic [1:0] int_clr = (wr_acc && idx == ffm_pkg::IDX_INT_STAT) ?
                              avs_writedata[1:0] : 2'h0;
   // set wins over write-one-to-clear
   wire logic [1:0] next_int_status = (int_status & ~int_clr) | int_evt;

   ////////////////////////////////////////////////////////////////////////
   // read selection
   wire logic [7:0] rd_mux =
      (idx == ffm_pkg::IDX_CFG) ? freefall_motion_config :
      (idx == ffm_pkg::IDX_SRC) ? src_view :
      (idx == ffm_pkg::IDX_THS) ? freefall_motion_common_threshold :
      (idx == ffm_pkg::IDX_COUNT) ? debounce_count :
      hit_ath ? axis_ths[ath_idx] :
      (idx == ffm_pkg::IDX_INT_STAT) ? {6'h00, int_status} :
      (idx == ffm_pkg::IDX_INT_MASK) ? {6'h00, int_mask} :
      (idx == ffm_pkg::IDX_INT_CTRL) ? {6'h00, int_ctrl} : 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // bus handshake: one wait cycle, data loaded before release
   always_ff @(posedge clk) begin
      if (!nrst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         avs_waitrequest <= ~(req & avs_waitrequest);
         if (req & avs_waitrequest) begin
            avs_readdata <= {24'h00_0000, rd_mux};
         end
      end
   end

   // software writes to control registers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         freefall_motion_config <= ffm_pkg::CFG_RST;
         freefall_motion_common_threshold <= ffm_pkg::THS_RST;
         debounce_count <= ffm_pkg::COUNT_RST;
         int_mask <= ffm_pkg::INT_RST;
         int_ctrl <= ffm_pkg::INT_RST;
      end else if (wr_acc) begin
         case (idx)
            ffm_pkg::IDX_CFG: begin
               freefall_motion_config <= avs_writedata[7:0] &
                                         ffm_pkg::CFG_MASK;
            end
            ffm_pkg::IDX_THS: begin
               freefall_motion_common_threshold <= avs_writedata[7:0];
            end
            ffm_pkg::IDX_COUNT: debounce_count <= avs_writedata[7:0];
            ffm_pkg::IDX_INT_MASK: int_mask <= avs_writedata[1:0];
            ffm_pkg::IDX_INT_CTRL: int_ctrl <= avs_writedata[1:0];
            default: ; // others written elsewhere, read-only or unmapped
         endcase
      end
   end

   // per-axis threshold bytes, addressed by index
   always_ff @(posedge clk) begin
      if (!nrst) begin
         for (int i = 0; i < 6; i++) begin
            axis_ths[i] <= ffm_pkg::ATH_RST;
         end
      end else if (wr_acc && hit_ath) begin
         axis_ths[ath_idx] <= avs_writedata[7:0];
      end
   end

   // debounce advances once per sample
   always_ff @(posedge clk) begin
      if (!nrst) begin
         dbcnt <= 8'h00;
         deb_state <= 1'b0;
      end else if (sample_valid) begin
         dbcnt <= next_dbcnt;
         deb_state <= next_deb;
      end
   end

   // event flag and source flags
   always_ff @(posedge clk) begin
      if (!nrst) begin
         event_active_flag <= 1'b0;
         freefall_motion_source <= 6'h00;
      end else begin
         event_active_flag <= next_ea;
         freefall_motion_source <= next_src;
      end
   end

   // sticky status, level interrupt and routed pins
   always_ff @(posedge clk) begin
      if (!nrst) begin
         int_status <= ffm_pkg::INT_RST;
         irq <= 1'b0;
         int1_freefall_motion <= 1'b0;
         int2_freefall_motion <= 1'b0;
      end else begin
         int_status <= next_int_status;
         irq <= |(next_int_status & int_mask);
         int1_freefall_motion <= next_ea & int_ctrl[ffm_pkg::CTRL_EN] &
                                 int_ctrl[ffm_pkg::CTRL_ROUTE];
         int2_freefall_motion <= next_ea & int_ctrl[ffm_pkg::CTRL_EN] &
                                 ~int_ctrl[ffm_pkg::CTRL_ROUTE];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   a_freefall_and: assert property (
      (sample_valid && !or_mode && !latch &&
       debounce_count == 8'h00) |=> event_active_flag == $past(cond_and))
      else $error("freefall flag does not match and of axes");
   a_motion_or: assert property (
      (sample_valid && or_mode && !latch &&
       debounce_count == 8'h00) |=> event_active_flag == $past(cond_or))
      else $error("motion flag does not match or of axes");
   a_latch_hold: assert property (
      (latch && event_active_flag && !src_read) |=> event_active_flag)
      else $error("latched flag dropped without source read");
   a_live_follow: assert property (
      (sample_valid && !latch) |=> event_active_flag == $past(next_deb))
      else $error("unlatched flag does not follow detection");
   a_src_read_clear: assert property (
      (src_read && latch && !sample_valid) |=>
         (!event_active_flag && freefall_motion_source == 6'h00))
      else $error("source read did not clear latched flags");
   a_flags_frozen: assert property (
      (latch && event_active_flag && !src_read) |=>
         $stable(freefall_motion_source))
      else $error("frozen source flags changed");
   a_axis_masked: assert property (
      (avs_read && avs_waitrequest && idx == ffm_pkg::IDX_SRC &&
       !axis_en[0]) |=> avs_readdata[1:0] == 2'h0)
      else $error("disabled x axis flags read nonzero");
   a_cfg_low_zero: assert property (
      (wr_acc && idx == ffm_pkg::IDX_CFG) |=>
         (freefall_motion_config[2:0] == 3'h0 &&
          freefall_motion_config[7:3] == $past(avs_writedata[7:3])))
      else $error("config write stored wrongly");
   a_dbnc_clear: assert property (
      (sample_valid && dbmode && !cond) |=> (dbcnt == 8'h00 && !deb_state))
      else $error("clear mode debounce did not reset");
   a_pin_route: assert property (
      1'b1 |=> int1_freefall_motion == $past(next_ea &&
         int_ctrl[ffm_pkg::CTRL_EN] && int_ctrl[ffm_pkg::CTRL_ROUTE]))
      else $error("pin 1 interrupt mismatch");
   a_bus_answer: assert property (
      (req && avs_waitrequest) |=> !avs_waitrequest)
      else $error("bus answer not after one wait cycle");
   a_wait_one_cycle: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("bus answer held longer than one cycle");

   // enables, source masking, pin routing and sticky status
   a_no_axis_quiet: assert property (
      (sample_valid && axis_en == 3'h0 && !latch &&
       debounce_count == 8'h00) |=> !event_active_flag)
      else $error("event flag set with no axis enabled");
   a_axis_z_masked: assert property (
      (avs_read && avs_waitrequest && idx == ffm_pkg::IDX_SRC &&
       !axis_en[2]) |=> avs_readdata[5:4] == 2'h0)
      else $error("disabled z axis flags read nonzero");
   a_axis_y_masked: assert property (
      (avs_read && avs_waitrequest && idx == ffm_pkg::IDX_SRC &&
       !axis_en[1]) |=> avs_readdata[3:2] == 2'h0)
      else $error("disabled y axis flags read nonzero");
   a_pin2_route: assert property (
      1'b1 |=> int2_freefall_motion == $past(next_ea &&
         int_ctrl[ffm_pkg::CTRL_EN] && !int_ctrl[ffm_pkg::CTRL_ROUTE]))
      else $error("pin 2 interrupt mismatch");
   a_status_sticky: assert property (
      (int_status[ffm_pkg::INT_RISE] && !(wr_acc &&
       idx == ffm_pkg::IDX_INT_STAT &&
       avs_writedata[ffm_pkg::INT_RISE])) |=>
         int_status[ffm_pkg::INT_RISE])
      else $error("sticky rise status dropped without clear");

   c_freefall: cover property (sample_valid && !or_mode && next_deb);
   c_motion: cover property (sample_valid && or_mode && next_deb);
   c_latched_clear: cover property (latch && event_active_flag ##1
                                    src_read);
   c_irq_raise: cover property (!irq ##1 irq);
   c_debounce_hold: cover property (sample_valid && !dbmode && !cond &&
                                    deb_state && next_deb);
endmodule
`default_nettype wire

//--- core/ffm_pkg.sv
// shared constants of the freefall / motion detector
package ffm_pkg;
   // data widths
   localparam int ACC_W = 14; // acceleration sample, two's complement
   localparam int CTH_W = 7; // common threshold field
   localparam int ATH_W = 13; // per-axis threshold
   localparam int COMMON_SHIFT = 6; // common threshold lsb weight as a shift, 64 counts
   typedef logic [ACC_W-1:0] ffm_acc_t;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CFG = 8'h15;
   localparam logic [7:0] IDX_SRC = 8'h16;
   localparam logic [7:0] IDX_THS = 8'h17;
   localparam logic [7:0] IDX_COUNT = 8'h18;
   localparam logic [7:0] IDX_THS_XM = 8'h73;
   localparam logic [7:0] IDX_THS_ZL = 8'h78;
   localparam logic [7:0] IDX_INT_STAT = 8'h7A;
   localparam logic [7:0] IDX_INT_MASK = 8'h7B;
   localparam logic [7:0] IDX_INT_CTRL = 8'h7C;
   // configuration fields
   localparam int CFG_LATCH = 7;
   localparam int CFG_OR = 6;
   localparam int CFG_XEN = 3; // y at +1, z at +2
   localparam logic [7:0] CFG_MASK = 8'hF8; // low three bits unused
   // threshold fields
   localparam int THS_DBMODE = 7;
   localparam int THS_XYZ_EN = 7; // in the x high-byte register
   localparam int ATH_HI_W = ATH_W - 8;
   // source fields
   localparam int SRC_EA = 7;
   // interrupt fields
   localparam int INT_RISE = 0;
   localparam int INT_FALL = 1;
   localparam int CTRL_EN = 0;
   localparam int CTRL_ROUTE = 1; // 1 routes to pin 1
   // reset values
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] THS_RST = 8'h00;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [7:0] ATH_RST = 8'h00;
   localparam logic [1:0] INT_RST = 2'h0;
endpackage

//--- sim/tb_ffm_detector.sv
`timescale 1ns/100ps
`default_nettype none
module tb_ffm_detector;
   // one ordinary case: config, samples, compare mask, expected source
   typedef struct packed {
      logic [7:0] cfg;
      logic [13:0] x;
      logic [13:0] y;
      logic [13:0] z;
      logic [7:0] mask;
      logic [7:0] exp;
   } ffm_row_s;
   localparam logic [13:0] LO = 14'h0064; // 100 counts, below 1024
   localparam logic [13:0] HI = 14'h07D0; // 2000 counts, above 1024
   localparam logic [13:0] NHI = 14'h3830; // -2000 counts
   logic clk;
   logic nrst;
   logic [9:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [13:0] accel_x;
   logic [13:0] accel_y;
   logic [13:0] accel_z;
   logic sample_valid;
   logic irq;
   logic int1_freefall_motion;
   logic int2_freefall_motion;
   int n_mismatch;
   int checks;
   logic [7:0] rd;
   logic [3:0] be;
   // common threshold 0x10 gives 1024 counts; flag is immediate (count 0)
   ffm_row_s rows [11] = '{
      '{8'h38, LO, LO, LO, 8'h80, 8'h80}, '{8'h38, HI, LO, LO, 8'h80, 8'h00},
      '{8'h28, LO, HI, LO, 8'h80, 8'h80}, '{8'h00, LO, LO, LO, 8'h80, 8'h00},
      '{8'h78, LO, LO, LO, 8'hFF, 8'h00}, '{8'h78, LO, NHI, LO, 8'hFF, 8'h8C},
      '{8'h50, HI, LO, NHI, 8'hFF, 8'h00}, '{8'h70, LO, LO, NHI, 8'hFF, 8'hB0},
      '{8'h78, 14'h0400, LO, LO, 8'hFF, 8'h00},
      '{8'h78, 14'h0401, LO, LO, 8'hFF, 8'h82},
      '{8'h78, 14'h3BFF, LO, LO, 8'hFF, 8'h83}};
   logic [7:0] rst_idx [8] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h73, 8'h7A,
                               8'h7B, 8'h7C};
   logic [7:0] ath [6] = '{8'h80, 8'h64, 8'h10, 8'h00, 8'h1F, 8'hFF};
   logic [13:0] dbx [8] = '{LO, HI, HI, LO, HI, HI, LO, LO};
   logic [7:0] dbe [8] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h80, 8'h80,
                           8'h00};

   ffm_detector DUT (.clk(clk), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
      .sample_valid(sample_valid), .irq(irq),
      .int1_freefall_motion(int1_freefall_motion),
      .int2_freefall_motion(int2_freefall_motion));

   ////////////////////////////////////////////////////////////////////////
   // clock, 50 ns period
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // watchdog against a hung sequence
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      $display("mismatch watchdog expected finish seen timeout");
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // compare one byte, report and count
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] idx,
                      input logic [7:0] wd, output logic [7:0] q);
      int n;
      @(posedge clk);
      avs_address <= {idx, 2'b00};
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= {24'h000000, wd};
      avs_byteenable <= be;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      // no answer within the bound ends the run
      if (avs_waitrequest !== 1'b0) begin
         n_mismatch++;
         $display("mismatch waitrequest expected 0 seen %b", avs_waitrequest);
         end_of_test();
      end else begin
         // answer edge: take read data, then release the request
         q = avs_readdata[7:0];
         avs_read <= 1'b0;
         avs_write <= 1'b0;
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, idx, d, q);
   endtask
   // read a register and compare
   task automatic rdc(input string nm, input logic [7:0] idx,
                      input logic [7:0] e);
      bus(1'b0, idx, 8'h00, rd);
      chk(nm, e, rd);
   endtask
   // one sample pulse, returns at the following falling edge
   task automatic samp(input logic [13:0] x, input logic [13:0] y,
                       input logic [13:0] z);
      @(posedge clk);
      accel_x <= x;
      accel_y <= y;
      accel_z <= z;
      sample_valid <= 1'b1;
      @(posedge clk);
      sample_valid <= 1'b0;
      @(negedge clk);
   endtask
   // let registered pin outputs settle
   task automatic settle();
      repeat (2) @(negedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      nrst = 1'b0;
      avs_address = 10'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hF;
      accel_x = 14'h0000;
      accel_y = 14'h0000;
      accel_z = 14'h0000;
      sample_valid = 1'b0;
      n_mismatch = 0;
      checks = 0;
      be = 4'hF;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      // reset values, unused config bits, refused writes
      for (int k = 0; k < 8; k++) begin
         rdc("reset_value", rst_idx[k], 8'h00);
      end
      wr(ffm_pkg::IDX_CFG, 8'hFF);
      rdc("cfg_unused", ffm_pkg::IDX_CFG, 8'hF8);
      wr(ffm_pkg::IDX_CFG, 8'h00);
      wr(ffm_pkg::IDX_SRC, 8'hFF);
      rdc("src_readonly", ffm_pkg::IDX_SRC, 8'h00);
      wr(8'h40, 8'h55);
      rdc("unmapped", 8'h40, 8'h00);
      be = 4'hE;
      wr(ffm_pkg::IDX_CFG, 8'h38);
      be = 4'hF;
      rdc("byteenable", ffm_pkg::IDX_CFG, 8'h00);
      $display("test registers done");
      // ordinary cases, unlatched
      wr(ffm_pkg::IDX_THS, 8'h10);
      rdc("ths", ffm_pkg::IDX_THS, 8'h10);
      foreach (rows[k]) begin
         wr(ffm_pkg::IDX_CFG, rows[k].cfg);
         samp(rows[k].x, rows[k].y, rows[k].z);
         bus(1'b0, ffm_pkg::IDX_SRC, 8'h00, rd);
         chk("src_row", rows[k].exp, rd & rows[k].mask);
      end
      $display("test rows done");
      // latched motion, pins and interrupt
      samp(LO, LO, LO);
      wr(ffm_pkg::IDX_INT_STAT, 8'h03);
      wr(ffm_pkg::IDX_INT_CTRL, 8'h03);
      wr(ffm_pkg::IDX_INT_MASK, 8'h01);
      wr(ffm_pkg::IDX_CFG, 8'hF8);
      samp(HI, LO, LO);
      settle();
      chk("int1", 8'h01, {7'h00, int1_freefall_motion});
      chk("int2", 8'h00, {7'h00, int2_freefall_motion});
      chk("irq", 8'h01, {7'h00, irq});
      samp(LO, NHI, LO);
      rdc("src_frozen", ffm_pkg::IDX_SRC, 8'h82);
      settle();
      chk("int1_clear", 8'h00, {7'h00, int1_freefall_motion});
      rdc("src_cleared", ffm_pkg::IDX_SRC, 8'h00);
      rdc("int_stat", ffm_pkg::IDX_INT_STAT, 8'h03);
      wr(ffm_pkg::IDX_INT_STAT, 8'h01);
      settle();
      chk("irq_clear", 8'h00, {7'h00, irq});
      rdc("int_stat_w1c", ffm_pkg::IDX_INT_STAT, 8'h02);
      wr(ffm_pkg::IDX_INT_CTRL, 8'h01);
      samp(HI, LO, LO);
      settle();
      chk("int2_route", 8'h01, {7'h00, int2_freefall_motion});
      chk("int1_route", 8'h00, {7'h00, int1_freefall_motion});
      rdc("src_latched", ffm_pkg::IDX_SRC, 8'h82);
      $display("test latched done");
      // own 13-bit thresholds per axis, unlatched motion
      wr(ffm_pkg::IDX_CFG, 8'h78);
      for (int k = 0; k < 6; k++) begin
         wr(ffm_pkg::IDX_THS_XM + 8'(k), ath[k]);
      end
      rdc("ths_xm", ffm_pkg::IDX_THS_XM, 8'h80);
      samp(14'h0065, 14'h1000, 14'h1FFF);
      rdc("indiv_x", ffm_pkg::IDX_SRC, 8'h82);
      samp(LO, 14'h1001, LO);
      rdc("indiv_y", ffm_pkg::IDX_SRC, 8'h88);
      samp(LO, LO, 14'h2000);
      rdc("indiv_z", ffm_pkg::IDX_SRC, 8'hB0);
      wr(ffm_pkg::IDX_THS_XM, 8'h00);
      $display("test per_axis done");
      // debounce count 2: clearing mode first, then decrementing mode
      wr(ffm_pkg::IDX_CFG, 8'h48);
      wr(ffm_pkg::IDX_COUNT, 8'h02);
      wr(ffm_pkg::IDX_THS, 8'h90);
      for (int k = 0; k < 8; k++) begin
         if (k == 4) begin
            wr(ffm_pkg::IDX_THS, 8'h10);
         end
         samp(dbx[k], LO, LO);
         bus(1'b0, ffm_pkg::IDX_SRC, 8'h00, rd);
         chk("debounce", dbe[k], rd & 8'h80);
      end
      $display("test debounce done");
      // second reset in mid-run
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rdc("cfg_rereset", ffm_pkg::IDX_CFG, 8'h00);
      rdc("src_rereset", ffm_pkg::IDX_SRC, 8'h00);
      $display("test reset done");
      end_of_test();
   end
endmodule
`default_nettype wire
